// [verilog/tlt_top.sv]
`default_nettype none

module tlt_top
	import tlt_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// avalon-mm slave
	input  wire logic [5:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest,
	// internal output clocks, bit 0 is clock one, bit 8 clock nine
	input  wire logic [8:0]  i_oc_clk,
	// lane a
	input  wire logic        i_tx_aux_in_a,
	input  wire logic        i_tx_serial_in_a,
	input  wire logic        i_line_float_pin_a,
	input  wire logic        i_frame_sync_a,
	input  wire logic        i_mframe_sync_a,
	output logic             o_tx_clock_out_a,
	output logic             o_tx_clock_out_a_oe,
	output logic             o_tx_sync_out_a,
	output logic             o_tx_sync_out_a_oe,
	output logic             o_line_pos_out_a,
	output logic             o_line_neg_out_a,
	output logic             o_line_out_a_oe,
	output logic             o_tx_data_a,
	// lane b
	input  wire logic        i_tx_aux_in_b,
	input  wire logic        i_tx_serial_in_b,
	input  wire logic        i_line_float_pin_b,
	input  wire logic        i_frame_sync_b,
	input  wire logic        i_mframe_sync_b,
	output logic             o_tx_clock_out_b,
	output logic             o_tx_clock_out_b_oe,
	output logic             o_tx_sync_out_b,
	output logic             o_tx_sync_out_b_oe,
	output logic             o_line_pos_out_b,
	output logic             o_line_neg_out_b,
	output logic             o_line_out_b_oe,
	output logic             o_tx_data_b
);

	localparam int STAT_W = TLT_LANES * TLT_STAT_STRIDE;

	typedef struct packed {
		tlt_ctl_type [TLT_LANES-1:0] ctl;
		logic [STAT_W-1:0]           stat_meta;
		logic [STAT_W-1:0]           stat_sync;
		logic                        ack;
		logic [31:0]                 rdata;
	} tlt_top_state_type;

	tlt_top_state_type st_ff;
	tlt_top_state_type nxt_st;

	logic [TLT_LANES-1:0] aux_in;
	logic [TLT_LANES-1:0] serial_in;
	logic [TLT_LANES-1:0] float_pin;
	logic [TLT_LANES-1:0] fsync_in;
	logic [TLT_LANES-1:0] mfsync_in;
	logic [TLT_LANES-1:0] clk_out;
	logic [TLT_LANES-1:0] clk_out_oe;
	logic [TLT_LANES-1:0] sync_out;
	logic [TLT_LANES-1:0] sync_out_oe;
	logic [TLT_LANES-1:0] line_pos;
	logic [TLT_LANES-1:0] line_neg;
	logic [TLT_LANES-1:0] line_oe;
	logic [TLT_LANES-1:0] tx_data;
	logic [STAT_W-1:0]    lane_stat;
	logic                 req;
	logic [1:0]           sel_lane;
	logic [3:0]           sel_ofs;
	logic                 lane_hit;

	tlt_lane_if lane_if [TLT_LANES] ();

	// ----------------------------------------------------------------
	// pin mapping, lane a is index 0
	// ----------------------------------------------------------------
	assign aux_in    = {i_tx_aux_in_b, i_tx_aux_in_a};
	assign serial_in = {i_tx_serial_in_b, i_tx_serial_in_a};
	assign float_pin = {i_line_float_pin_b, i_line_float_pin_a};
	assign fsync_in  = {i_frame_sync_b, i_frame_sync_a};
	assign mfsync_in = {i_mframe_sync_b, i_mframe_sync_a};

	assign o_tx_clock_out_a    = clk_out[0];
	assign o_tx_clock_out_a_oe = clk_out_oe[0];
	assign o_tx_sync_out_a     = sync_out[0];
	assign o_tx_sync_out_a_oe  = sync_out_oe[0];
	assign o_line_pos_out_a    = line_pos[0];
	assign o_line_neg_out_a    = line_neg[0];
	assign o_line_out_a_oe     = line_oe[0];
	assign o_tx_data_a         = tx_data[0];
	assign o_tx_clock_out_b    = clk_out[1];
	assign o_tx_clock_out_b_oe = clk_out_oe[1];
	assign o_tx_sync_out_b     = sync_out[1];
	assign o_tx_sync_out_b_oe  = sync_out_oe[1];
	assign o_line_pos_out_b    = line_pos[1];
	assign o_line_neg_out_b    = line_neg[1];
	assign o_line_out_b_oe     = line_oe[1];
	assign o_tx_data_b         = tx_data[1];

	// ----------------------------------------------------------------
	// lanes, each fully independent
	// ----------------------------------------------------------------
	for (genvar g = 0; g < TLT_LANES; g++) begin : g_lane
		assign lane_if[g].ctl = st_ff.ctl[g];
		assign lane_stat[g*TLT_STAT_STRIDE + TLT_STAT_ACTIVE] =
			lane_if[g].line_active;
		assign lane_stat[g*TLT_STAT_STRIDE + TLT_STAT_FLOAT] =
			lane_if[g].float_seen;

		tlt_tx_lane u_lane (
			.i_oc_clk         (i_oc_clk),
			.i_rst_n          (i_rst_n),
			.i_aux_in         (aux_in[g]),
			.i_serial_in      (serial_in[g]),
			.i_line_float_pin (float_pin[g]),
			.i_frame_sync     (fsync_in[g]),
			.i_mframe_sync    (mfsync_in[g]),
			.lane             (lane_if[g]),
			.o_clock_out      (clk_out[g]),
			.o_clock_out_oe   (clk_out_oe[g]),
			.o_sync_out       (sync_out[g]),
			.o_sync_out_oe    (sync_out_oe[g]),
			.o_line_pos       (line_pos[g]),
			.o_line_neg       (line_neg[g]),
			.o_line_oe        (line_oe[g]),
			.o_tx_data        (tx_data[g])
		);
	end

	// ----------------------------------------------------------------
	// avalon slave: one wait cycle on every access
	// ----------------------------------------------------------------
	assign req      = i_avs_read | i_avs_write;
	assign sel_lane = i_avs_address[5:4];
	assign sel_ofs  = i_avs_address[3:0];
	assign lane_hit = ~i_avs_address[5];

	always_comb begin
		nxt_st           = st_ff;
		nxt_st.stat_meta = lane_stat;
		nxt_st.stat_sync = st_ff.stat_meta;
		nxt_st.ack       = req & ~st_ff.ack;
		if (i_avs_read && !st_ff.ack) begin
			nxt_st.rdata = '0;
			if (i_avs_address == TLT_OFS_STATUS) begin
				nxt_st.rdata[STAT_W-1:0] = st_ff.stat_sync;
			end else if (lane_hit) begin
				case (sel_ofs)
					TLT_OFS_CLOCK_SELECT: begin
						nxt_st.rdata[3:0] =
							st_ff.ctl[sel_lane[0]].clock_source_select;
					end
					TLT_OFS_PIN_CONTROL: begin
						nxt_st.rdata[5:0] = {
							st_ff.ctl[sel_lane[0]].aux_mode,
							st_ff.ctl[sel_lane[0]].sync_out_select,
							st_ff.ctl[sel_lane[0]].sync_out_enable,
							st_ff.ctl[sel_lane[0]].clock_edge_invert,
							st_ff.ctl[sel_lane[0]].clock_out_enable};
					end
					TLT_OFS_LINK_MODE: begin
						nxt_st.rdata[1:0] =
							st_ff.ctl[sel_lane[0]].transmit_format;
					end
					TLT_OFS_LINE_CONTROL: begin
						nxt_st.rdata[1:0] = {
							st_ff.ctl[sel_lane[0]].transmitter_power_down,
							st_ff.ctl[sel_lane[0]].line_driver_enable};
					end
					default: begin
						nxt_st.rdata = '0;
					end
				endcase
			end
		end
		// a write lands on the edge after the wait, the one that completes the access
		if (i_avs_write && st_ff.ack && lane_hit) begin
			case (sel_ofs)
				TLT_OFS_CLOCK_SELECT: begin
					nxt_st.ctl[sel_lane[0]].clock_source_select =
						i_avs_writedata[3:0];
				end
				TLT_OFS_PIN_CONTROL: begin
					nxt_st.ctl[sel_lane[0]].clock_out_enable =
						i_avs_writedata[TLT_PIN_CLK_OUT_EN];
					nxt_st.ctl[sel_lane[0]].clock_edge_invert =
						i_avs_writedata[TLT_PIN_EDGE_INV];
					nxt_st.ctl[sel_lane[0]].sync_out_enable =
						i_avs_writedata[TLT_PIN_SYNC_OUT_EN];
					nxt_st.ctl[sel_lane[0]].sync_out_select =
						i_avs_writedata[TLT_PIN_SYNC_SEL];
					nxt_st.ctl[sel_lane[0]].aux_mode = tlt_aux_type'(
						i_avs_writedata[TLT_PIN_AUX_LSB +: 2]);
				end
				TLT_OFS_LINK_MODE: begin
					nxt_st.ctl[sel_lane[0]].transmit_format =
						i_avs_writedata[1:0];
				end
				TLT_OFS_LINE_CONTROL: begin
					nxt_st.ctl[sel_lane[0]].line_driver_enable =
						i_avs_writedata[TLT_LINE_DRV_EN];
					nxt_st.ctl[sel_lane[0]].transmitter_power_down =
						i_avs_writedata[TLT_LINE_PWR_DN];
				end
				default: begin
					nxt_st.ack = st_ff.ack & 1'b0;
				end
			endcase
		end
		if (!i_rst_n) begin
			nxt_st     = '0;
			nxt_st.ctl = {TLT_LANES{TLT_CTL_RST}};
		end
	end

	always_ff @(posedge i_clk) begin
		st_ff <= nxt_st;
	end

	assign o_avs_waitrequest = req & ~st_ff.ack;
	assign o_avs_readdata    = st_ff.rdata;

endmodule : tlt_top

`default_nettype wire

// [inc/tlt_pkg.sv]
`default_nettype none

package tlt_pkg;

	localparam int TLT_LANES = 2;

	// ----------------------------------------------------------------
	// register map (byte addresses; lane registers repeat per lane)
	// ----------------------------------------------------------------
	localparam logic [3:0] TLT_OFS_CLOCK_SELECT = 4'h0;
	localparam logic [3:0] TLT_OFS_PIN_CONTROL  = 4'h4;
	localparam logic [3:0] TLT_OFS_LINK_MODE    = 4'h8;
	localparam logic [3:0] TLT_OFS_LINE_CONTROL = 4'hc;
	localparam logic [5:0] TLT_OFS_STATUS       = 6'h20;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int TLT_PIN_CLK_OUT_EN  = 0;
	localparam int TLT_PIN_EDGE_INV    = 1;
	localparam int TLT_PIN_SYNC_OUT_EN = 2;
	localparam int TLT_PIN_SYNC_SEL    = 3;
	localparam int TLT_PIN_AUX_LSB     = 4;
	localparam int TLT_LINE_DRV_EN     = 0;
	localparam int TLT_LINE_PWR_DN     = 1;
	localparam int TLT_STAT_ACTIVE     = 0;
	localparam int TLT_STAT_FLOAT      = 1;
	localparam int TLT_STAT_STRIDE     = 2;

	// ----------------------------------------------------------------
	// clock source codes
	// ----------------------------------------------------------------
	localparam logic [3:0] TLT_CLKS_AUX_PIN = 4'h0;
	localparam logic [3:0] TLT_CLKS_OC_LAST = 4'h7;
	localparam logic [3:0] TLT_CLKS_OC_NINE = 4'h9;

	typedef enum logic [1:0] {
		TLT_AUX_NONE,
		TLT_AUX_FRAME,
		TLT_AUX_MFRAME
	} tlt_aux_type;

	typedef struct packed {
		logic [3:0]  clock_source_select;
		logic        clock_out_enable;
		logic        clock_edge_invert;
		logic        sync_out_enable;
		logic        sync_out_select;
		tlt_aux_type aux_mode;
		logic [1:0]  transmit_format;
		logic        line_driver_enable;
		logic        transmitter_power_down;
	} tlt_ctl_type;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] TLT_RST_CLOCK_SELECT = 4'h1;
	localparam logic [5:0] TLT_RST_PIN_CONTROL  = 6'h00;
	localparam logic [1:0] TLT_RST_LINK_MODE    = 2'h0;
	localparam logic [1:0] TLT_RST_LINE_CONTROL = 2'h0;

	localparam tlt_ctl_type TLT_CTL_RST = {TLT_RST_CLOCK_SELECT,
		TLT_RST_PIN_CONTROL[3:0], TLT_AUX_NONE, TLT_RST_LINK_MODE,
		TLT_RST_LINE_CONTROL[TLT_LINE_DRV_EN],
		TLT_RST_LINE_CONTROL[TLT_LINE_PWR_DN]};

endpackage : tlt_pkg

`default_nettype wire

// [inc/tlt_lane_if.sv]
`default_nettype none

interface tlt_lane_if
	import tlt_pkg::*;
	();

	tlt_ctl_type ctl;
	logic        line_active;
	logic        float_seen;

	modport ctl_side (
		output ctl,
		input  line_active,
		input  float_seen
	);

	modport lane_side (
		input  ctl,
		output line_active,
		output float_seen
	);

endinterface : tlt_lane_if

`default_nettype wire

// [verilog/tlt_tx_lane.sv]
`default_nettype none

module tlt_tx_lane
	import tlt_pkg::*;
(
	input  wire logic [8:0] i_oc_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_aux_in,
	input  wire logic       i_serial_in,
	input  wire logic       i_line_float_pin,
	input  wire logic       i_frame_sync,
	input  wire logic       i_mframe_sync,
	tlt_lane_if.lane_side   lane,
	output logic            o_clock_out,
	output logic            o_clock_out_oe,
	output logic            o_sync_out,
	output logic            o_sync_out_oe,
	output logic            o_line_pos,
	output logic            o_line_neg,
	output logic            o_line_oe,
	output logic            o_tx_data
);

	typedef struct packed {
		logic [1:0]  rst_sync;
		tlt_ctl_type ctl_meta;
		tlt_ctl_type ctl_sync;
		logic        float_meta;
		logic        float_sync;
		logic        data;
		logic        aux_smp;
		logic        sync_out;
		logic        sync_oe;
		logic        line_pos;
		logic        line_neg;
		logic        line_oe;
	} tlt_lane_state_type;

	tlt_lane_state_type st_ff;
	tlt_lane_state_type nxt_st;
	logic               tx_clk;
	logic               smp_clk;
	logic               ds1e1;
	logic               fsync;
	logic               mfsync;

	// ----------------------------------------------------------------
	// clock mux; select is static config, change only with line idle
	// ----------------------------------------------------------------
	always_comb begin
		tx_clk = 1'b0;
		if (lane.ctl.clock_source_select == TLT_CLKS_AUX_PIN) begin
			tx_clk = i_aux_in;
		end else if (lane.ctl.clock_source_select <= TLT_CLKS_OC_LAST) begin
			tx_clk = i_oc_clk[lane.ctl.clock_source_select - 4'h1];
		end else if (lane.ctl.clock_source_select == TLT_CLKS_OC_NINE) begin
			tx_clk = i_oc_clk[8];
		end
	end

	assign smp_clk        = tx_clk ^ lane.ctl.clock_edge_invert;
	assign o_clock_out    = tx_clk & lane.ctl.clock_out_enable;
	assign o_clock_out_oe = lane.ctl.clock_out_enable;

	// ----------------------------------------------------------------
	// link-side sampling and pin drive
	// ----------------------------------------------------------------
	assign ds1e1 = ~st_ff.ctl_sync.transmit_format[1];
	assign fsync = (st_ff.ctl_sync.aux_mode == TLT_AUX_FRAME) ?
		st_ff.aux_smp : i_frame_sync;
	assign mfsync = (st_ff.ctl_sync.aux_mode == TLT_AUX_MFRAME) ?
		st_ff.aux_smp : i_mframe_sync;

	always_comb begin
		nxt_st            = st_ff;
		nxt_st.rst_sync   = {st_ff.rst_sync[0], i_rst_n};
		nxt_st.ctl_meta   = lane.ctl;
		nxt_st.ctl_sync   = st_ff.ctl_meta;
		nxt_st.float_meta = i_line_float_pin;
		nxt_st.float_sync = st_ff.float_meta;
		// non-DS1/E1 formats never look at the serial pin
		nxt_st.data       = ds1e1 ? i_serial_in : 1'b1;
		nxt_st.aux_smp    = ds1e1 && i_aux_in &&
			(st_ff.ctl_sync.aux_mode != TLT_AUX_NONE) &&
			(st_ff.ctl_sync.clock_source_select != TLT_CLKS_AUX_PIN);
		nxt_st.sync_out   = st_ff.ctl_sync.sync_out_enable &
			(st_ff.ctl_sync.sync_out_select ? mfsync : fsync);
		nxt_st.sync_oe    = st_ff.ctl_sync.sync_out_enable;
		nxt_st.line_oe    = ~st_ff.float_sync &
			st_ff.ctl_sync.line_driver_enable &
			~st_ff.ctl_sync.transmitter_power_down;
		nxt_st.line_pos   = nxt_st.line_oe & st_ff.data;
		nxt_st.line_neg   = nxt_st.line_oe & ~st_ff.data;
		// reset from the register clock passes both flops before use
		if (!st_ff.rst_sync[1]) begin
			nxt_st          = '0;
			nxt_st.rst_sync = {st_ff.rst_sync[0], i_rst_n};
			nxt_st.ctl_meta = TLT_CTL_RST;
			nxt_st.ctl_sync = TLT_CTL_RST;
		end
	end

	always_ff @(posedge smp_clk) begin
		st_ff <= nxt_st;
	end

	assign o_sync_out       = st_ff.sync_out;
	assign o_sync_out_oe    = st_ff.sync_oe;
	assign o_line_pos       = st_ff.line_pos;
	assign o_line_neg       = st_ff.line_neg;
	assign o_line_oe        = st_ff.line_oe;
	assign o_tx_data        = st_ff.data;
	assign lane.line_active = st_ff.line_oe;
	assign lane.float_seen  = st_ff.float_sync;

endmodule : tlt_tx_lane

`default_nettype wire

// [dv/tlt_far_model.sv]
`default_nettype none

module tlt_far_model (
	input  wire logic        i_tx_clk,
	input  wire logic        i_edge_inv,
	input  wire logic        i_run,
	input  wire logic [31:0] i_word,
	input  wire logic        i_aux_lvl,
	output logic             o_serial,
	output logic             o_aux
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [31:0] sh_ff = 32'hffff_ffff;

	initial begin
		o_serial = 1'b1;
		o_aux    = 1'b0;
	end

	// launch on the edge opposite the device's sampling edge
	always @(negedge (i_tx_clk ^ i_edge_inv)) begin
		o_aux <= i_aux_lvl;
		if (!i_run) begin
			o_serial <= 1'b0;
		end else begin
			o_serial <= sh_ff[31];
			sh_ff    <= {sh_ff[30:0], sh_ff[31] ^ sh_ff[21] ^ i_word[7]};
		end
	end
endmodule : tlt_far_model

`default_nettype wire

// [dv/tlt_top_asserts.sv]
`default_nettype none

module tlt_top_asserts (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic [5:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [31:0] o_avs_readdata,
	input  wire logic        o_avs_waitrequest,
	input  wire logic        o_tx_clock_out_a,
	input  wire logic        o_tx_clock_out_a_oe,
	input  wire logic        o_tx_clock_out_b,
	input  wire logic        o_tx_clock_out_b_oe,
	input  wire logic        i_line_float_pin_a,
	input  wire logic        o_line_pos_out_a,
	input  wire logic        o_line_neg_out_a,
	input  wire logic        o_line_out_a_oe,
	input  wire logic        o_tx_data_a
);
	logic [1:0] fmt_ff;
	logic [1:0] age_ff;
	logic       acc;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	// track lane a format and how long it has been in force
	assign acc = (i_avs_read | i_avs_write) & !o_avs_waitrequest;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			fmt_ff <= 2'h0;
			age_ff <= 2'h0;
		end else if (acc && i_avs_write && i_avs_address == 6'h08) begin
			fmt_ff <= i_avs_writedata[1:0];
			age_ff <= 2'h0;
		end else if (age_ff != 2'h3) begin
			age_ff <= age_ff + 2'h1;
		end
	end

	chk_wait_one: assert property ($rose(i_avs_read || i_avs_write)
		|-> o_avs_waitrequest ##1 !o_avs_waitrequest)
		else $error("request not answered after one wait state");
	chk_idle_nowait: assert property (!(i_avs_read || i_avs_write)
		|-> !o_avs_waitrequest) else $error("waitrequest while idle");
	chk_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest
		&& i_avs_address > 6'h20 |-> o_avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_field_narrow: assert property (i_avs_read && !o_avs_waitrequest
		|-> o_avs_readdata[31:6] == 26'h000_0000)
		else $error("unused register bits not zero");
	chk_clk_gate_a: assert property (
		!o_tx_clock_out_a_oe |-> !o_tx_clock_out_a)
		else $error("lane a clock pin active while disabled");
	chk_clk_gate_b: assert property (
		!o_tx_clock_out_b_oe |-> !o_tx_clock_out_b)
		else $error("lane b clock pin active while disabled");
	chk_line_quiet: assert property (
		!o_line_out_a_oe |-> !o_line_pos_out_a && !o_line_neg_out_a)
		else $error("line driven while floating");
	chk_line_diff: assert property (
		o_line_out_a_oe |-> o_line_pos_out_a != o_line_neg_out_a)
		else $error("line pair not complementary");
	chk_float_pin: assert property (
		i_line_float_pin_a [*3] |-> !o_line_out_a_oe)
		else $error("line still driven with float pin high");
	chk_serial_ignore: assert property (
		fmt_ff[1] && age_ff == 2'h3 |-> o_tx_data_a)
		else $error("serial input used outside ds1 and e1");
endmodule : tlt_top_asserts

bind tlt_top tlt_top_asserts u_chk (.i_clk, .i_rst_n, .i_avs_address,
	.i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata,
	.o_avs_waitrequest, .o_tx_clock_out_a, .o_tx_clock_out_a_oe,
	.o_tx_clock_out_b, .o_tx_clock_out_b_oe, .i_line_float_pin_a,
	.o_line_pos_out_a, .o_line_neg_out_a, .o_line_out_a_oe, .o_tx_data_a);

`default_nettype wire

// [dv/tlt_top_tb.sv]
`default_nettype none

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end

module tlt_top_tb
	import tlt_pkg::*;
	;
	timeunit 1ns;
	timeprecision 100ps;

	logic        i_clk, lclk, i_rst_n = 1'b0, oc_run = 1'b1, chk_on = 1'b0;
	logic        i_avs_read = 1'b0, i_avs_write = 1'b0, run_a = 1'b1;
	logic [5:0]  i_avs_address = 6'h00;
	logic [31:0] i_avs_writedata = 32'h0000_0000, o_avs_readdata, r;
	logic [31:0] word_a = 32'h0000_0000, word_b = 32'h0000_0000;
	logic [31:0] rs = 32'h0000_0015;
	logic [8:0]  oc_bits = 9'h000;
	logic [1:0]  aux_st = 2'h0;
	logic        aux_lvl = 1'b0, aux_fa, aux_fb, o_avs_waitrequest;
	logic        i_line_float_pin_a = 1'b0, i_line_float_pin_b = 1'b0;
	logic        i_frame_sync_a = 1'b0, i_mframe_sync_a = 1'b0;
	logic        i_frame_sync_b = 1'b0, i_mframe_sync_b = 1'b0;
	logic        o_tx_clock_out_a, o_tx_clock_out_a_oe, o_tx_sync_out_a;
	logic        o_tx_clock_out_b, o_tx_clock_out_b_oe, o_tx_sync_out_b;
	logic        o_tx_sync_out_a_oe, o_line_pos_out_a, o_line_neg_out_a;
	logic        o_tx_sync_out_b_oe, o_line_pos_out_b, o_line_neg_out_b;
	logic        o_line_out_a_oe, o_tx_data_a, o_line_out_b_oe, o_tx_data_b;
	wire logic [8:0] i_oc_clk = oc_run ? {9{lclk}} : oc_bits;
	wire logic   i_tx_aux_in_a = oc_run ? aux_fa : aux_st[0];
	wire logic   i_tx_aux_in_b = oc_run ? aux_fb : aux_st[1];
	wire logic   i_tx_serial_in_a, i_tx_serial_in_b;
	logic [31:0] mdl [0:7] = '{32'h0000_0001, 32'h0, 32'h0, 32'h0,
		32'h0000_0001, 32'h0, 32'h0, 32'h0};
	logic [31:0] msk [0:3] = '{32'h0000_000f, 32'h0000_003f,
		32'h0000_0003, 32'h0000_0003};
	logic [31:0] cfg [0:7] = '{32'h0000_0001, 32'h0000_0001, 32'h0,
		32'h0000_0001, 32'h0000_0001, 32'h0000_0001, 32'h0000_0002,
		32'h0000_0001};
	logic        q_a [$];
	int          n_errors = 0, check_count = 0;

	tlt_top DUT (.i_clk, .i_rst_n, .i_avs_address, .i_avs_read, .i_avs_write,
		.i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_oc_clk,
		.i_tx_aux_in_a, .i_tx_serial_in_a, .i_line_float_pin_a,
		.i_frame_sync_a, .i_mframe_sync_a, .o_tx_clock_out_a,
		.o_tx_clock_out_a_oe, .o_tx_sync_out_a, .o_tx_sync_out_a_oe,
		.o_line_pos_out_a, .o_line_neg_out_a, .o_line_out_a_oe, .o_tx_data_a,
		.i_tx_aux_in_b, .i_tx_serial_in_b, .i_line_float_pin_b,
		.i_frame_sync_b, .i_mframe_sync_b, .o_tx_clock_out_b,
		.o_tx_clock_out_b_oe, .o_tx_sync_out_b, .o_tx_sync_out_b_oe,
		.o_line_pos_out_b, .o_line_neg_out_b, .o_line_out_b_oe, .o_tx_data_b);

	tlt_far_model far_a (.i_tx_clk(o_tx_clock_out_a), .i_edge_inv(mdl[1][1]),
		.i_run(run_a), .i_word(word_a), .i_aux_lvl(aux_lvl),
		.o_serial(i_tx_serial_in_a), .o_aux(aux_fa));
	tlt_far_model far_b (.i_tx_clk(o_tx_clock_out_b), .i_edge_inv(mdl[5][1]),
		.i_run(1'b1), .i_word(word_b), .i_aux_lvl(aux_lvl),
		.o_serial(i_tx_serial_in_b), .o_aux(aux_fb));

	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	initial begin
		lclk = 1'b0;
		#3.7;
		forever #6 lclk = ~lclk;
	end

	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction : rnd

	function automatic logic line_on(input int l);
		return mdl[l*4+3][0] & !mdl[l*4+3][1]
			& !(l ? i_line_float_pin_b : i_line_float_pin_a);
	endfunction : line_on

	function automatic logic [31:0] exp_rd(input logic [5:0] a);
		if (a == TLT_OFS_STATUS)
			return {28'h000_0000, i_line_float_pin_b, line_on(1),
				i_line_float_pin_a, line_on(0)};
		if (a < 6'h20 && a[1:0] == 2'b00)
			return mdl[a[4:2]];
		return 32'h0000_0000;
	endfunction : exp_rd

	function automatic logic clk_exp(input logic [3:0] c, input logic aux);
		if (c == TLT_CLKS_AUX_PIN) return aux;
		if (c == TLT_CLKS_OC_NINE) return oc_bits[8];
		if (c <= TLT_CLKS_OC_LAST) return oc_bits[c - 4'h1];
		return 1'b0;
	endfunction : clk_exp

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict

	task automatic avs(input logic wr, input logic [5:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n = 0;
		@(posedge i_clk);
		i_avs_write     <= wr;
		i_avs_read      <= !wr;
		i_avs_address   <= a;
		i_avs_writedata <= d;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_avs_waitrequest !== 1'b0 && n < 20);
		if (o_avs_waitrequest !== 1'b0) begin
			n_errors++;
			give_verdict();
		end
		q = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read  <= 1'b0;
	endtask : avs

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		avs(1'b1, a, d, q);
		if (a < 6'h20 && a[1:0] == 2'b00) mdl[a[4:2]] = d & msk[a[3:2]];
	endtask : wr

	task automatic rdc(input logic [5:0] a);
		logic [31:0] q;
		avs(1'b0, a, 32'h0000_0000, q);
		`CHK(q, exp_rd(a))
	endtask : rdc

	task automatic idle(input int n);
		repeat (n) @(posedge i_clk);
	endtask : idle

	// model of the serial path: data at the sampling edge, line one later
	always @(posedge (o_tx_clock_out_a ^ mdl[1][1])) begin
		q_a.push_back(mdl[2][1] ? 1'b1 : i_tx_serial_in_a);
		#1;
		if (chk_on && q_a.size() > 2) begin
			`CHK(o_tx_data_a, q_a[$])
			if (o_line_out_a_oe) `CHK(o_line_pos_out_a, q_a[$-1])
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		idle(5);
		i_rst_n <= 1'b1;
		for (int i = 0; i < 10; i++) rdc(6'(i * 4));
		for (int i = 0; i < 10; i++) begin
			r = rnd();
			if (i[1:0] == 2'b00) r[3:0] = 4'h1;
			wr(6'(i * 4), r);
			if (i != 8) rdc(6'(i * 4));
		end
		for (int i = 0; i < 8; i++) wr(6'(i * 4), cfg[i]);
		$display("test registers done");
		oc_run <= 1'b0;
		for (int c = 0; c < 20; c++) begin
			r = rnd();
			oc_bits <= r[8:0];
			aux_st  <= r[10:9];
			wr(6'h00, {28'h000_0000, 4'(c / 2)});
			wr(6'h10, {28'h000_0000, 4'(9 - c / 2)});
			idle(1);
			`CHK(o_tx_clock_out_a, clk_exp(mdl[0][3:0], aux_st[0]))
			`CHK(o_tx_clock_out_b, clk_exp(mdl[4][3:0], aux_st[1]))
		end
		wr(6'h04, 32'h0000_0000);
		idle(1);
		`CHK(o_tx_clock_out_a_oe, 1'b0)
		`CHK(o_tx_clock_out_a, 1'b0)
		wr(6'h04, 32'h0000_0001);
		idle(1);
		`CHK(o_tx_clock_out_a_oe, 1'b1)
		oc_run <= 1'b1;
		wr(6'h00, 32'h0000_0001);
		wr(6'h10, 32'h0000_0001);
		$display("test clock select done");
		for (int k = 0; k < 8; k++) begin
			wr(6'h04, {30'h0000_0000, k[2], 1'b1});
			wr(6'h08, {30'h0000_0000, k[1:0]});
			word_a <= rnd();
			word_b <= rnd();
			run_a  <= !k[1];
			idle(4);
			chk_on = 1'b1;
			idle(40);
			chk_on = 1'b0;
			`CHK(o_tx_data_b, 1'b1)
		end
		wr(6'h04, 32'h0000_0001);
		wr(6'h08, 32'h0000_0000);
		$display("test serial data done");
		for (int j = 0; j < 12; j++) begin
			r = rnd();
			wr(6'h0c, {30'h0000_0000, r[1:0]});
			wr(6'h1c, {30'h0000_0000, r[5:4]});
			i_line_float_pin_a <= r[2];
			i_line_float_pin_b <= r[6];
			idle(4);
			`CHK(o_line_out_a_oe, line_on(0))
			`CHK(o_line_out_b_oe, line_on(1))
			`CHK({o_line_pos_out_b, o_line_neg_out_b}, {line_on(1), 1'b0})
			rdc(TLT_OFS_STATUS);
		end
		$display("test line drivers done");
		for (int m = 0; m < 8; m++) begin
			r = rnd();
			{i_frame_sync_a, i_mframe_sync_a, aux_lvl} <= r[2:0];
			{i_frame_sync_b, i_mframe_sync_b} <= r[4:3];
			wr(6'h04, {26'h000_0000, m[1] ? (m[0] ? 2'h2 : 2'h1) : 2'h0,
				m[0], m[2], 2'b01});
			wr(6'h14, {28'h000_0000, m[0], m[2], 2'b01});
			idle(4);
			r[0] = m[1] ? aux_lvl : (m[0] ? i_mframe_sync_a : i_frame_sync_a);
			r[1] = m[0] ? i_mframe_sync_b : i_frame_sync_b;
			`CHK(o_tx_sync_out_a_oe, m[2])
			`CHK(o_tx_sync_out_a, m[2] & r[0])
			`CHK(o_tx_sync_out_b_oe, m[2])
			`CHK(o_tx_sync_out_b, m[2] & r[1])
		end
		$display("test sync output done");
		give_verdict();
	end
endmodule : tlt_top_tb

`default_nettype wire
